// file: logic/cca_counter_array.sv
// Five-channel capture/compare unit on a shared 16-bit counter, with an APB register slave.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/100ps
module cca_counter_array (
    // Clock and reset.
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst,
    // APB slave.
    input  wire cca_pkg::cca_apb_req_t i_apb,
    output cca_pkg::cca_apb_rsp_t      o_apb,
    // Channel pins.
    input  wire logic [4:0]            i_channel_pin,
    output logic      [4:0]            o_channel_pin,
    output logic      [4:0]            o_channel_pin_oe_n,
    // Combined interrupt request.
    output logic                       o_irq
);

    // Decodes a channel mode byte into its operating mode.
    function automatic cca_pkg::cca_mode_t mode_of(input logic [7:0] m);
        cca_pkg::cca_mode_t r;
        r = cca_pkg::CCA_IDLE;
        if (m[cca_pkg::MB_RISE] | m[cca_pkg::MB_FALL]) begin
            if (m[3:1] == 3'h0) begin
                r = cca_pkg::CCA_CAP;
            end
        end else if (m[cca_pkg::MB_PWM] & m[cca_pkg::MB_TOG]) begin
            r = cca_pkg::CCA_FREQ;
        end else if (m[cca_pkg::MB_PWM]) begin
            r = m[cca_pkg::MB_WIDE] ? cca_pkg::CCA_PWM16 : cca_pkg::CCA_PWM_ENABLE;
        end else if (m[cca_pkg::MB_MAT] & m[cca_pkg::MB_TOG]) begin
            r = cca_pkg::CCA_TOGGLE;
        end else if (m[cca_pkg::MB_MAT]) begin
            r = cca_pkg::CCA_TIMER;
        end
        return r;
    endfunction

    // Mask of the low N counter bits for a cycle-length code.
    function automatic logic [15:0] low_mask(input logic [1:0] cls);
        logic [4:0] n;
        n = 5'(cca_pkg::PWM_BASE_BITS) + {3'h0, cls};
        return 16'((17'h00001 << n) - 17'h00001);
    endfunction

    cca_pkg::cca_state_t r_r;
    cca_pkg::cca_state_t r_nxt;

    logic [15:0] mask;
    logic        short_ovf;
    logic        low0;
    logic        wrap;
    logic        acc_start;
    logic        acc_done;
    logic [11:0] rel;
    logic [2:0]  sel_ch;
    logic        ch_hit;
    logic        map_hit;

    // Shared counter events while counting: short overflow of bit N, and the zero counts that follow overflows.
    always_comb begin
        mask      = low_mask(r_r.pwmc[1:0]);
        short_ovf = r_r.run & ((r_r.cnt & mask) == mask);
        low0      = r_r.run & ~|(r_r.cnt & mask);
        wrap      = r_r.run & ~|r_r.cnt;
    end

    // Address decode: a read answer is built on the first access cycle, a write lands on the second.
    always_comb begin
        acc_start = i_apb.psel & i_apb.penable & ~r_r.rsp.pready;
        acc_done  = i_apb.psel & i_apb.penable & r_r.rsp.pready & i_apb.pwrite;
        rel       = i_apb.paddr - cca_pkg::ADDR_CH0;
        sel_ch    = 3'(rel >> 4);
        ch_hit    = (i_apb.paddr >= cca_pkg::ADDR_CH0) && (sel_ch < 3'(cca_pkg::NCH))
                    && (rel[3:0] <= cca_pkg::OFS_HIGH[3:0]) && (rel[1:0] == 2'h0);
        map_hit   = ch_hit || (i_apb.paddr == cca_pkg::ADDR_CTRL) || (i_apb.paddr == cca_pkg::ADDR_FLAGS)
                    || (i_apb.paddr == cca_pkg::ADDR_PWMC) || (i_apb.paddr == cca_pkg::ADDR_CNT);
    end

    // Next-state logic: counter, channel engines, then the bus, whose writes come last and win data.
    always_comb begin
        logic              ecom;
        logic              mat;
        logic              m16;
        logic              m8;
        logic              mn;
        logic              set;
        logic              irq;
        logic              rise;
        logic              fall;
        logic [15:0]       wdat;
        cca_pkg::cca_mode_t md;
        ecom  = 1'b0;
        mat   = 1'b0;
        m16   = 1'b0;
        m8    = 1'b0;
        mn    = 1'b0;
        set   = 1'b0;
        irq   = 1'b0;
        rise  = 1'b0;
        fall  = 1'b0;
        wdat  = 16'h0000;
        md    = cca_pkg::CCA_IDLE;
        r_nxt = r_r;
        r_nxt.cnt = r_r.run ? r_r.cnt + 16'h0001 : r_r.cnt;
        // The short overflow flag is shared by all PWM channels.
        if (short_ovf) begin
            r_nxt.short_overflow_flag = 1'b1;
        end

        for (int i = 0; i < cca_pkg::NCH; i++) begin
            md   = mode_of(r_r.ch[i].mode);
            ecom = r_r.ch[i].mode[cca_pkg::MB_ECOM];
            mat  = r_r.ch[i].mode[cca_pkg::MB_MAT];
            m16  = r_r.run & ecom & (r_r.cnt == r_r.ch[i].cpr);
            m8   = r_r.run & ecom & (r_r.cnt[7:0] == r_r.ch[i].cpr[7:0]);
            mn   = r_r.run & ecom & ((r_r.cnt & mask) == (r_r.ch[i].cpr & mask));
            set  = 1'b0;
            // The first synchroniser stage feeds only the second.
            r_nxt.ch[i].sync1 = i_channel_pin[i];
            r_nxt.ch[i].sync2 = r_r.ch[i].sync1;
            r_nxt.ch[i].sync3 = r_r.ch[i].sync2;
            rise = r_r.ch[i].sync2 & ~r_r.ch[i].sync3;
            fall = ~r_r.ch[i].sync2 & r_r.ch[i].sync3;
            r_nxt.ch[i].oe_n = 1'b1;
            case (md)
                cca_pkg::CCA_CAP: begin
                    if ((rise & r_r.ch[i].mode[cca_pkg::MB_RISE]) | (fall & r_r.ch[i].mode[cca_pkg::MB_FALL])) begin
                        r_nxt.ch[i].cpr = r_r.cnt;
                        set             = 1'b1;
                    end
                end
                cca_pkg::CCA_TIMER: begin
                    set = m16;
                end
                cca_pkg::CCA_TOGGLE: begin
                    r_nxt.ch[i].oe_n = 1'b0;
                    // A cleared comparator enable leaves the pin where it was.
                    if (m16) begin
                        r_nxt.ch[i].pin = ~r_r.ch[i].pin;
                    end
                    set = m16 & mat;
                end
                cca_pkg::CCA_FREQ: begin
                    r_nxt.ch[i].oe_n = 1'b0;
                    // Adding a zero step wraps the low byte fully, giving the 256-clock half period.
                    if (m8) begin
                        r_nxt.ch[i].pin      = ~r_r.ch[i].pin;
                        r_nxt.ch[i].cpr[7:0] = r_r.ch[i].cpr[7:0] + r_r.ch[i].cpr[15:8];
                    end
                    set = m16 & mat;
                end
                cca_pkg::CCA_PWM_ENABLE: begin
                    r_nxt.ch[i].oe_n = 1'b0;
                    if (r_r.pwmc[1:0] == 2'h0) begin
                        // Eight-bit flavour reloads the low byte from the high byte.
                        if (short_ovf) begin
                            r_nxt.ch[i].cpr[7:0] = r_r.ch[i].cpr[15:8];
                        end
                        // Both edges land one count late; a match wins, so a zero compare stays high.
                        if (m8 | low0) begin
                            r_nxt.ch[i].pin = m8;
                        end
                        set = m8 & mat;
                    end else begin
                        if (short_ovf) begin
                            r_nxt.ch[i].cpr = r_r.ch[i].arl;
                        end
                        if (mn | low0) begin
                            r_nxt.ch[i].pin = mn;
                        end
                        set = mn & mat;
                    end
                    if (!ecom) begin
                        r_nxt.ch[i].pin = 1'b0;
                    end
                end
                cca_pkg::CCA_PWM16: begin
                    r_nxt.ch[i].oe_n = 1'b0;
                    if (m16 | wrap) begin
                        r_nxt.ch[i].pin = m16;
                    end
                    set = m16 & mat;
                    if (!ecom) begin
                        r_nxt.ch[i].pin = 1'b0;
                    end
                end
                default: begin
                    set = 1'b0;
                end
            endcase
            // Only software clears the flag; a set in the same cycle wins.
            if (acc_done && i_apb.paddr == cca_pkg::ADDR_FLAGS && i_apb.pwdata[i]) begin
                r_nxt.ch[i].flag = 1'b0;
            end
            if (set) begin
                r_nxt.ch[i].flag = 1'b1;
            end
        end

        if (acc_done && i_apb.paddr == cca_pkg::ADDR_FLAGS && i_apb.pwdata[cca_pkg::FB_SHORT_OVERFLOW_FLAG] && !short_ovf) begin
            r_nxt.short_overflow_flag = 1'b0;
        end

        // Register writes take effect on the edge that completes the access.
        if (acc_done) begin
            wdat = {i_apb.pwdata[7:0], i_apb.pwdata[7:0]};
            case (i_apb.paddr)
                cca_pkg::ADDR_CTRL: r_nxt.run  = i_apb.pwdata[cca_pkg::CB_RUN];
                cca_pkg::ADDR_PWMC: r_nxt.pwmc = i_apb.pwdata[7:0] & cca_pkg::PWMC_MASK;
                cca_pkg::ADDR_CNT:  r_nxt.cnt  = i_apb.pwdata[15:0];
                default: begin
                    if (ch_hit) begin
                        if (rel[3:0] == cca_pkg::OFS_MODE[3:0]) begin
                            r_nxt.ch[sel_ch].mode = i_apb.pwdata[7:0];
                        end else if (rel[3:0] == cca_pkg::OFS_LOW[3:0]) begin
                            r_nxt.ch[sel_ch].mode[cca_pkg::MB_ECOM] = 1'b0;
                            if (r_r.pwmc[cca_pkg::PB_RELOAD_REG_SELECT]) begin
                                r_nxt.ch[sel_ch].arl[7:0] = wdat[7:0];
                            end else begin
                                r_nxt.ch[sel_ch].cpr[7:0] = wdat[7:0];
                            end
                        end else begin
                            r_nxt.ch[sel_ch].mode[cca_pkg::MB_ECOM] = 1'b1;
                            if (r_r.pwmc[cca_pkg::PB_RELOAD_REG_SELECT]) begin
                                r_nxt.ch[sel_ch].arl[15:8] = wdat[15:8];
                            end else begin
                                r_nxt.ch[sel_ch].cpr[15:8] = wdat[15:8];
                            end
                        end
                    end
                end
            endcase
        end

        // Read answer, error for unmapped addresses; pready stands for exactly one cycle.
        r_nxt.rsp.pready  = acc_start;
        r_nxt.rsp.pslverr = acc_start & ~map_hit;
        r_nxt.rsp.prdata  = 32'h0000_0000;
        if (acc_start && !i_apb.pwrite) begin
            case (i_apb.paddr)
                cca_pkg::ADDR_CTRL:  r_nxt.rsp.prdata = {31'h0, r_r.run};
                cca_pkg::ADDR_FLAGS: begin
                    r_nxt.rsp.prdata[cca_pkg::FB_SHORT_OVERFLOW_FLAG] = r_r.short_overflow_flag;
                    for (int i = 0; i < cca_pkg::NCH; i++) begin
                        r_nxt.rsp.prdata[i] = r_r.ch[i].flag;
                    end
                end
                cca_pkg::ADDR_PWMC:  r_nxt.rsp.prdata = {24'h0, r_r.pwmc};
                cca_pkg::ADDR_CNT:   r_nxt.rsp.prdata = {16'h0, r_r.cnt};
                default: begin
                    if (ch_hit) begin
                        if (rel[3:0] == cca_pkg::OFS_MODE[3:0]) begin
                            r_nxt.rsp.prdata = {24'h0, r_r.ch[sel_ch].mode};
                        end else if (rel[3:0] == cca_pkg::OFS_LOW[3:0]) begin
                            r_nxt.rsp.prdata = {24'h0, r_r.pwmc[cca_pkg::PB_RELOAD_REG_SELECT] ?
                                                r_r.ch[sel_ch].arl[7:0] : r_r.ch[sel_ch].cpr[7:0]};
                        end else begin
                            r_nxt.rsp.prdata = {24'h0, r_r.pwmc[cca_pkg::PB_RELOAD_REG_SELECT] ?
                                                r_r.ch[sel_ch].arl[15:8] : r_r.ch[sel_ch].cpr[15:8]};
                        end
                    end
                end
            endcase
        end

        // Interrupt request from the current flags and enables.
        irq = r_r.short_overflow_flag & r_r.pwmc[cca_pkg::PB_SHORT_OVERFLOW_IRQ_ENABLE];
        for (int i = 0; i < cca_pkg::NCH; i++) begin
            irq = irq | (r_r.ch[i].flag & r_r.ch[i].mode[cca_pkg::MB_IRQ_EN]);
        end
        r_nxt.irq = irq;
    end

    // State register; reset gives every field a constant.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            r_r <= '0;
            for (int i = 0; i < cca_pkg::NCH; i++) begin
                r_r.ch[i].mode <= cca_pkg::RST_MODE;
                r_r.ch[i].cpr  <= cca_pkg::RST_WORD;
                r_r.ch[i].arl  <= cca_pkg::RST_WORD;
                r_r.ch[i].oe_n <= 1'b1;
            end
            r_r.pwmc <= cca_pkg::RST_PWMC;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Outputs straight from the state register.
    always_comb begin
        o_apb = r_r.rsp;
        o_irq = r_r.irq;
        for (int i = 0; i < cca_pkg::NCH; i++) begin
            o_channel_pin[i]      = r_r.ch[i].pin;
            o_channel_pin_oe_n[i] = r_r.ch[i].oe_n;
        end
    end

endmodule

// file: logic/cca_pkg.sv
// Package with the register map, field layout, types and carriers of the counter array capture/compare block.
// What this block does
// - Each of five channels picks its own mode, independent of the others.
// - All 8 to 11-bit PWM channels share one cycle-length setting.
// - Channel interrupt asserts when its event flag and mode bit 0 are both set.
// - Mode bit 5 captures rising, bit 4 falling, both any edge; bits 3-1 clear.
// - Bit 3 timer; bits 3,2 toggle; bits 2,1 frequency; bit 1 PWM, bit 7 wide.
// - PWM config bits 1-0 select 8, 9, 10 or 11-bit cycle.
// - PWM config bit 7 steers compare byte accesses to the auto-reload register.
// - PWM config bit 5 enables interrupt on the short overflow of bit N.
// - Comparator enable clear: no toggling, PWM output held low.
// - With match-flag enable set, every comparator match sets the event flag, save low-byte matches in frequency mode.
// - Capture loads the 16-bit counter into the channel register and sets the flag.
// - Event flags stay set until software clears them.
// - Software timer sets the event flag when counter equals compare word.
// - Writing the low byte clears comparator enable; writing the high byte sets it.
// - Toggle mode inverts the pin on each 16-bit match while enabled.
// - Frequency mode matches low bytes, toggles, and adds high byte into low byte.
// - A high byte of zero gives a half period of 256 counter clocks.
// - Frequency mode with match-flag enable flags on full 16-bit equality.
// - 8-bit PWM goes high on low byte match, low on low byte overflow.
// - 8-bit PWM reloads the low byte from the high byte at rollover.
// - 8-bit PWM sets the short overflow flag every 256 counter clocks.
// - 9-11 bit PWM matches low N bits, drops and reloads at bit N overflow.
// - 16-bit PWM goes high on word match and low on counter overflow.
package cca_pkg;

    localparam int NCH = 5;

    // Byte addresses of the register map.
    localparam logic [11:0] ADDR_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_FLAGS = 12'h004;
    localparam logic [11:0] ADDR_PWMC  = 12'h008;
    localparam logic [11:0] ADDR_CNT   = 12'h00C;
    localparam logic [11:0] ADDR_CH0   = 12'h010;
    localparam logic [11:0] CH_STRIDE  = 12'h010;
    localparam logic [11:0] OFS_MODE   = 12'h000;
    localparam logic [11:0] OFS_LOW    = 12'h004;
    localparam logic [11:0] OFS_HIGH   = 12'h008;

    // Field positions of the channel mode register.
    localparam int MB_IRQ_EN = 0;
    localparam int MB_PWM    = 1;
    localparam int MB_TOG    = 2;
    localparam int MB_MAT    = 3;
    localparam int MB_FALL   = 4;
    localparam int MB_RISE   = 5;
    localparam int MB_ECOM   = 6;
    localparam int MB_WIDE   = 7;

    // Field positions of the PWM configuration, control and flag registers.
    localparam int PB_RELOAD_REG_SELECT  = 7;
    localparam int PB_SHORT_OVERFLOW_IRQ_ENABLE   = 5;
    localparam int CB_RUN    = 0;
    localparam int FB_SHORT_OVERFLOW_FLAG   = 5;

    // Reset values.
    localparam logic [7:0]  RST_MODE = 8'h00;
    localparam logic [7:0]  RST_PWMC = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Cycle length base and bit masks.
    localparam int           PWM_BASE_BITS = 8;
    localparam logic [7:0]   PWMC_MASK     = 8'hA3;
    localparam logic [15:0]  CNT_MAX       = 16'hFFFF;

    typedef enum logic [2:0] {
        CCA_IDLE   = 3'b000,
        CCA_CAP    = 3'b001,
        CCA_TIMER  = 3'b010,
        CCA_TOGGLE = 3'b011,
        CCA_FREQ   = 3'b100,
        CCA_PWM_ENABLE   = 3'b101,
        CCA_PWM16  = 3'b110
    } cca_mode_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cca_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } cca_apb_rsp_t;

    typedef struct packed {
        logic [7:0]  mode;
        logic [15:0] cpr;
        logic [15:0] arl;
        logic        flag;
        logic        pin;
        logic        oe_n;
        logic        sync1;
        logic        sync2;
        logic        sync3;
    } cca_chan_t;

    typedef struct packed {
        cca_chan_t [NCH-1:0] ch;
        logic [15:0]         cnt;
        logic                run;
        logic [7:0]          pwmc;
        logic                short_overflow_flag;
        logic                irq;
        cca_apb_rsp_t        rsp;
    } cca_state_t;

endpackage

// file: verif/cca_checker.sv
// Checker for the port behaviour of the counter array capture/compare block.
`timescale 1ns/100ps
module cca_checker (
    // Clock and reset.
    input wire logic                  i_ref_clk,
    input wire logic                  i_rst,
    // APB side.
    input wire cca_pkg::cca_apb_req_t i_apb,
    input wire cca_pkg::cca_apb_rsp_t o_apb,
    // Channel pins and interrupt.
    input wire logic [4:0]            i_channel_pin,
    input wire logic [4:0]            o_channel_pin,
    input wire logic [4:0]            o_channel_pin_oe_n,
    input wire logic                  o_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    logic acc;
    logic wr_done;
    // Access phase and completed write, as seen at the bus.
    assign acc     = i_apb.psel && i_apb.penable;
    assign wr_done = acc && o_apb.pready && i_apb.pwrite;

    apb_answer_a: assert property (acc && !o_apb.pready |=> o_apb.pready)
        else $error("ready did not follow the access cycle");
    wait_state_a: assert property ($rose(acc) |-> !o_apb.pready)
        else $error("ready came without the wait cycle");
    ready_pulse_a: assert property (o_apb.pready |=> !o_apb.pready)
        else $error("ready stood longer than one cycle");
    ready_cause_a: assert property ($rose(o_apb.pready) |-> $past(acc))
        else $error("ready rose without an access");
    err_ready_a: assert property (o_apb.pslverr |-> o_apb.pready && o_apb.prdata == 32'h00000000)
        else $error("error response without ready or with data");
    reset_out_a: assert property ($past(i_rst) |-> o_channel_pin == 5'h00 && o_channel_pin_oe_n == 5'h1F
                                  && !o_irq && !o_apb.pready)
        else $error("outputs not idle after reset");
    irq_hold_a: assert property ($fell(o_irq) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("interrupt fell without a software write");
    oe_hold_a: assert property (!$stable(o_channel_pin_oe_n) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("pin direction moved without a mode write");

    // Main scenarios reached.
    wr_seen_c: cover property (wr_done);
    err_seen_c: cover property (o_apb.pslverr);
    irq_seen_c: cover property ($rose(o_irq));
endmodule

// file: verif/cca_pin_src.sv
// Behavioural source of the external levels on the five channel pins.
`timescale 1ns/100ps
module cca_pin_src (
    // Clock.
    input  wire logic       i_ref_clk,
    // Requested levels and the design's own drive.
    input  wire logic [4:0] i_lvl,
    input  wire logic [4:0] i_dut_pin,
    input  wire logic [4:0] i_dut_oe_n,
    // Resolved wire level.
    output logic      [4:0] o_pin
);
    logic [4:0] lvl_r = 5'h00;
    // Levels move only on clock edges; the bench holds each for several cycles.
    always_ff @(posedge i_ref_clk) begin
        lvl_r <= i_lvl;
    end
    // Where the design drives a pin, its level wins over the external source.
    assign o_pin = (i_dut_oe_n & lvl_r) | (~i_dut_oe_n & i_dut_pin);
endmodule

// file: verif/tb_top.sv
// Self-checking testbench of the counter array capture/compare block.
`timescale 1ns/100ps
module tb_top;
    logic                  i_ref_clk = 1'b0;
    logic                  i_rst     = 1'b1;
    cca_pkg::cca_apb_req_t apb_req   = '0;
    cca_pkg::cca_apb_rsp_t apb_rsp;
    logic [4:0]            src_lvl   = 5'h00;
    logic [4:0]            pin_in;
    logic [4:0]            pin_out;
    logic [4:0]            pin_oe_n;
    logic                  irq;
    logic [31:0]           rd;
    logic                  err;
    int                    n_mismatch = 0;
    int                    compares   = 0;
    int                    cycles     = 0;
    int                    n;
    logic [7:0]            cap_m [3]  = '{8'h20, 8'h10, 8'h30};
    logic [15:0]           hv [2]     = '{16'h0004, 16'h0000};

    cca_counter_array dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_apb(apb_req), .o_apb(apb_rsp),
        .i_channel_pin(pin_in), .o_channel_pin(pin_out), .o_channel_pin_oe_n(pin_oe_n), .o_irq(irq));
    cca_pin_src src (.i_ref_clk(i_ref_clk), .i_lvl(src_lvl), .i_dut_pin(pin_out), .i_dut_oe_n(pin_oe_n),
        .o_pin(pin_in));

    // Free-running 50 MHz clock.
    always #10 i_ref_clk = ~i_ref_clk;

    // A hung test is cut short here rather than left to run on.
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge i_ref_clk);
    endtask

    // One APB transfer; the request holds until ready is sampled high, then an idle edge follows.
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {16'h0000, d}};
        @(posedge i_ref_clk);
        apb_req.penable <= 1'b1;
        @(posedge i_ref_clk);
        while (apb_rsp.pready !== 1'b1) begin
            @(posedge i_ref_clk);
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge i_ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string what, input logic [11:0] a, input logic [15:0] exp);
        apb(1'b0, a, 16'h0000);
        chk(what, rd, {16'h0000, exp});
    endtask

    function automatic logic [11:0] ca(input logic [11:0] c, input logic [11:0] o);
        return cca_pkg::ADDR_CH0 + cca_pkg::CH_STRIDE * c + o;
    endfunction

    // Waits for the pin to reach a level, then counts how long it stays there.
    task automatic span(input int c, input logic lv, output int m);
        m = 0;
        while (pin_out[c] !== lv && m < 3000) begin
            m++;
            @(posedge i_ref_clk);
        end
        m = 0;
        while (pin_out[c] === lv && m < 3000) begin
            m++;
            @(posedge i_ref_clk);
        end
    endtask

    initial begin
        tick(5);
        i_rst <= 1'b0;
        tick(1);
        // Configuration register access and a refused address.
        rdc("pwm_config_reset", cca_pkg::ADDR_PWMC, 16'h0000);
        wr(cca_pkg::ADDR_PWMC, 16'h00FF);
        rdc("pwm_config_bits", cca_pkg::ADDR_PWMC, 16'h00A3);
        apb(1'b0, 12'hFFC, 16'h0000);
        chk("unmapped_error", {31'h0, err}, 32'h00000001);
        wr(cca_pkg::ADDR_PWMC, 16'h0000);
        $display("test registers done");
        // Software timer on channel 0; byte writes move the comparator enable.
        wr(ca(0, cca_pkg::OFS_MODE), 16'h0049);
        wr(ca(0, cca_pkg::OFS_LOW), 16'h0020);
        rdc("mode_after_low", ca(0, cca_pkg::OFS_MODE), 16'h0009);
        wr(ca(0, cca_pkg::OFS_HIGH), 16'h0000);
        rdc("mode_after_high", ca(0, cca_pkg::OFS_MODE), 16'h0049);
        wr(cca_pkg::ADDR_CNT, 16'h0000);
        wr(cca_pkg::ADDR_CTRL, 16'h0001);
        tick(40);
        rdc("timer_flag", cca_pkg::ADDR_FLAGS, 16'h0001);
        chk("timer_irq", {31'h0, irq}, 32'h00000001);
        wr(cca_pkg::ADDR_FLAGS, 16'h0001);
        tick(1);
        chk("irq_cleared", {31'h0, irq}, 32'h00000000);
        wr(ca(0, cca_pkg::OFS_MODE), 16'h0000);
        $display("test timer done");
        // Capture on channel 1 for each edge selection, counter stopped.
        wr(cca_pkg::ADDR_CTRL, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            wr(ca(1, cca_pkg::OFS_MODE), {8'h00, cap_m[i]});
            wr(cca_pkg::ADDR_CNT, 16'h1230 + 16'(i));
            wr(cca_pkg::ADDR_FLAGS, 16'h003F);
            src_lvl[1] <= 1'b1;
            tick(6);
            rdc("flag_after_rise", cca_pkg::ADDR_FLAGS, {14'h0000, cap_m[i][5], 1'b0});
            src_lvl[1] <= 1'b0;
            tick(6);
            rdc("flag_after_fall", cca_pkg::ADDR_FLAGS, 16'h0002);
            rdc("capture_low", ca(1, cca_pkg::OFS_LOW), 16'h0030 + 16'(i));
            rdc("capture_high", ca(1, cca_pkg::OFS_HIGH), 16'h0012);
        end
        wr(ca(1, cca_pkg::OFS_MODE), 16'h0000);
        $display("test capture done");
        // Toggle output on channel 2, then the same with the comparator disabled.
        wr(ca(2, cca_pkg::OFS_MODE), 16'h004C);
        wr(ca(2, cca_pkg::OFS_LOW), 16'h0010);
        wr(ca(2, cca_pkg::OFS_HIGH), 16'h0000);
        wr(cca_pkg::ADDR_CNT, 16'h0000);
        wr(cca_pkg::ADDR_CTRL, 16'h0001);
        tick(40);
        chk("toggle_pin", {27'h0, pin_out}, 32'h00000004);
        chk("toggle_drive", {27'h0, pin_oe_n}, 32'h0000001B);
        wr(ca(2, cca_pkg::OFS_LOW), 16'h0010);
        wr(cca_pkg::ADDR_CNT, 16'h0000);
        tick(40);
        chk("toggle_held", {31'h0, pin_out[2]}, 32'h00000001);
        $display("test toggle done");
        // Frequency output on channel 3, short and 256-count half periods.
        wr(ca(3, cca_pkg::OFS_MODE), 16'h0046);
        wr(ca(3, cca_pkg::OFS_LOW), 16'h0000);
        for (int i = 0; i < 2; i++) begin
            wr(ca(3, cca_pkg::OFS_HIGH), hv[i]);
            span(3, 1'b1, n);
            span(3, 1'b1, n);
            chk("half_period", n, (hv[i] == 16'h0000) ? 256 : 32'(hv[i]));
        end
        $display("test frequency done");
        // 8-bit PWM on channel 4 with the short overflow interrupt.
        wr(cca_pkg::ADDR_PWMC, 16'h0020);
        wr(ca(4, cca_pkg::OFS_MODE), 16'h0042);
        wr(ca(4, cca_pkg::OFS_LOW), 16'h00C0);
        wr(ca(4, cca_pkg::OFS_HIGH), 16'h00C0);
        span(4, 1'b1, n);
        span(4, 1'b1, n);
        chk("pwm8_high", n, 32'd64);
        apb(1'b0, cca_pkg::ADDR_FLAGS, 16'h0000);
        chk("short_ovf_flag", rd & 32'h00000020, 32'h00000020);
        chk("short_ovf_irq", {31'h0, irq}, 32'h00000001);
        wr(cca_pkg::ADDR_FLAGS, 16'h003F);
        // 9-bit PWM through the auto-reload register.
        wr(cca_pkg::ADDR_PWMC, 16'h0081);
        wr(ca(4, cca_pkg::OFS_LOW), 16'h0000);
        wr(ca(4, cca_pkg::OFS_HIGH), 16'h0001);
        wr(cca_pkg::ADDR_PWMC, 16'h0001);
        span(4, 1'b1, n);
        span(4, 1'b1, n);
        chk("pwm9_high", n, 32'd256);
        // 16-bit PWM near the counter wrap.
        wr(ca(4, cca_pkg::OFS_MODE), 16'h00C2);
        wr(ca(4, cca_pkg::OFS_LOW), 16'h0000);
        wr(ca(4, cca_pkg::OFS_HIGH), 16'h00FF);
        wr(cca_pkg::ADDR_CNT, 16'hFE00);
        span(4, 1'b1, n);
        chk("pwm16_high", n, 32'd256);
        $display("test pwm done");
        finish_test();
    end
endmodule

bind cca_counter_array cca_checker chk_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_apb(i_apb), .o_apb(o_apb),
    .i_channel_pin(i_channel_pin), .o_channel_pin(o_channel_pin), .o_channel_pin_oe_n(o_channel_pin_oe_n),
    .o_irq(o_irq));
